// ===== rtl/iepf_pkg.sv
package iepf_pkg;
  // register byte addresses
  localparam logic [7:0] A_MAIN = 8'h00;
  localparam logic [7:0] A_EDGE = 8'h04;
  localparam logic [7:0] A_EXT  = 8'h08;
  localparam logic [7:0] A_FLG  = 8'h0C;
  localparam logic [7:0] A_PEN  = 8'h10;
  localparam logic [7:0] A_PRI  = 8'h14;
  localparam logic [7:0] A_PCFG = 8'h18;
  localparam logic [7:0] A_PORT = 8'h1C;

  // reset values
  localparam logic [7:0] R_MAIN = 8'h00;
  localparam logic [7:0] R_EDGE = 8'hF5;
  localparam logic [7:0] R_EXT  = 8'hC0;
  localparam logic [7:0] R_FLG  = 8'h00;
  localparam logic [7:0] R_PEN  = 8'h00;
  localparam logic [7:0] R_PRI  = 8'h00;
  localparam logic [7:0] R_PCFG = 8'h00;

  // implemented-bit masks
  localparam logic [7:0] M_EDGE = 8'hF5;
  localparam logic [7:0] M_EXT  = 8'hDB;
  localparam logic [7:0] M_FLG  = 8'h4F;
  localparam logic [7:0] M_PEN  = 8'h7F;

  // main control fields
  localparam int B_GHI  = 7;
  localparam int B_PLO  = 6;
  localparam int B_T0E  = 5;
  localparam int B_I0E  = 4;
  localparam int B_RBE  = 3;
  localparam int B_T0F  = 2;
  localparam int B_I0F  = 1;
  localparam int B_RBF  = 0;
  // edge, pull-up and priority fields
  localparam int B_PUD  = 7;
  localparam int B_ED0  = 6;
  localparam int B_ED1  = 5;
  localparam int B_ED2  = 4;
  localparam int B_T0P  = 2;
  localparam int B_RBP  = 0;
  // external control fields
  localparam int B_I2P  = 7;
  localparam int B_I1P  = 6;
  localparam int B_I2E  = 4;
  localparam int B_I1E  = 3;
  localparam int B_I2F  = 1;
  localparam int B_I1F  = 0;
  // peripheral flag fields
  localparam int B_ADF  = 6;
  localparam int B_RXF  = 5;
  localparam int B_TXF  = 4;
  localparam int B_SSF  = 3;
  localparam int B_CCF  = 2;
  localparam int B_T2F  = 1;
  localparam int B_T1F  = 0;

  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  // event sources, all synchronous to pclk
  typedef struct packed {
    logic       tmr0_ovf;
    logic [2:0] ext_lines;
    logic       adc_done;
    logic       ssp_done;
    logic       ccp_event;
    logic       ccp_pwm_mode;
    logic       tmr2_match;
    logic       tmr1_ovf;
    logic       rx_full;
    logic       tx_empty;
  } iepf_evt_t;

  // request towards the core
  typedef struct packed {
    logic        high;
    logic        low;
    logic [15:0] vector;
  } iepf_irq_t;
endpackage

// ===== rtl/iepf_top.sv
`timescale 1ns/1ps
module iepf_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire iepf_pkg::iepf_evt_t events,
  input  wire logic [3:0]          port_b_pins,
  input  wire logic [3:0]          pin_is_input,
  input  wire logic                priority_mode_enable,
  output logic      [3:0]          pullup_on,
  output iepf_pkg::iepf_irq_t      irq
);
  import iepf_pkg::*;

  logic [7:0]  main_r;
  logic [7:0]  edge_r;
  logic [7:0]  ext_r;
  logic [7:0]  flg_r;
  logic [7:0]  pen_r;
  logic [7:0]  pri_r;
  logic [7:0]  pcfg_r;
  logic [3:0]  port_snap_r;
  logic [2:0]  line_q_r;
  logic        rx_r;
  logic        tx_r;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd_port;
  logic [2:0]  edge_sel;
  logic [2:0]  ext_hit;
  logic [3:0]  mismatch;
  logic [7:0]  set_main;
  logic [7:0]  set_ext;
  logic [7:0]  set_flg;
  logic [7:0]  flg_view;
  logic [4:0]  pend_core;
  logic [4:0]  prio_core;
  logic [6:0]  pend_per;
  logic [6:0]  prio_per;
  logic        high_nxt;
  logic        low_nxt;
  logic [31:0] rdata_nxt;
  logic        err_nxt;

  // apb phases; zero wait states, read data is latched in the setup cycle
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd_port = access & ~pwrite & (paddr == A_PORT);
  assign pready  = access;

  // edge detect on the external lines; inputs arrive synchronous to pclk
  // per-line edge polarity
  assign edge_sel = {edge_r[B_ED2], edge_r[B_ED1], edge_r[B_ED0]};
  assign ext_hit  = (edge_sel & events.ext_lines & ~line_q_r)
                  | (~edge_sel & ~events.ext_lines & line_q_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q_r <= 3'h0;
    end else begin
      line_q_r <= events.ext_lines;
    end
  end

  // mismatch against the value seen at the last port read
  assign mismatch = port_b_pins ^ port_snap_r;

  // snapshot only moves on a port read, so a held change keeps re-setting the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_snap_r <= 4'h0;
    end else if (rd_port) begin
      port_snap_r <= port_b_pins;
    end
  end

  // hardware set terms, independent of every enable
  // flags set regardless of enables
  always_comb begin
    set_main        = 8'h00;
    set_main[B_T0F] = events.tmr0_ovf;
    set_main[B_I0F] = ext_hit[0];
    set_main[B_RBF] = |mismatch;
    set_ext         = 8'h00;
    set_ext[B_I1F]  = ext_hit[1];
    set_ext[B_I2F]  = ext_hit[2];
    set_flg         = 8'h00;
    set_flg[B_ADF]  = events.adc_done;
    set_flg[B_SSF]  = events.ssp_done;
    // capture/compare flag idle in pulse-width mode
    set_flg[B_CCF]  = events.ccp_event & ~events.ccp_pwm_mode;
    set_flg[B_T2F]  = events.tmr2_match;
    set_flg[B_T1F]  = events.tmr1_ovf;
  end

  // main control: enables and sticky flags
  // timer-0 flag sticky
  // set term ORed after the write so the event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_r <= R_MAIN;
    end else if (wr && paddr == A_MAIN) begin
      main_r <= pwdata[7:0] | set_main;
    end else begin
      main_r <= main_r | set_main;
    end
  end

  // edge select, pull-up disable and priorities; no hardware set terms
  // timer-0 and port-change priority storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_r <= R_EDGE;
    end else if (wr && paddr == A_EDGE) begin
      edge_r <= pwdata[7:0] & M_EDGE;
    end
  end

  // external-1/2 priorities, enables and sticky flags
  // priority bits kept here
  // sticky flags with set over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_r <= R_EXT;
    end else if (wr && paddr == A_EXT) begin
      ext_r <= (pwdata[7:0] & M_EXT) | set_ext;
    end else begin
      ext_r <= ext_r | set_ext;
    end
  end

  // peripheral flags; receive and transmit bits are never stored here
  // conversion flag sticky
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg_r <= R_FLG;
    end else if (wr && paddr == A_FLG) begin
      flg_r <= (pwdata[7:0] & M_FLG) | set_flg;
    end else begin
      flg_r <= flg_r | set_flg;
    end
  end

  // buffer status mirrors; the serial block clears them on buffer access
  // receive flag follows buffer full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      rx_r <= events.rx_full;
      tx_r <= events.tx_empty;
    end
  end

  always_comb begin
    flg_view        = flg_r;
    flg_view[B_RXF] = rx_r;
    flg_view[B_TXF] = tx_r;
  end

  // peripheral enable and priority banks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_r <= R_PEN;
      pri_r <= R_PRI;
    end else if (wr && paddr == A_PEN) begin
      pen_r <= pwdata[7:0] & M_PEN;
    end else if (wr && paddr == A_PRI) begin
      pri_r <= pwdata[7:0] & M_PEN;
    end
  end

  // pin config: [3:0] change enables, [7:4] pull-up enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcfg_r <= R_PCFG;
    end else if (wr && paddr == A_PCFG) begin
      pcfg_r <= pwdata[7:0];
    end
  end

  // pull-up drive
  // global disable overrides per-pin enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_on <= 4'h0;
    end else if (edge_r[B_PUD]) begin
      pullup_on <= 4'h0;
    end else begin
      pullup_on <= pin_is_input & pcfg_r[7:4];
    end
  end

  // pending sources: tmr0, ext0, port change, ext1, ext2
  // port change needs an enabled changing pin
  // priority bits only read in the priority branch below
  assign pend_core = {main_r[B_T0F] & main_r[B_T0E],
                      main_r[B_I0F] & main_r[B_I0E],
                      main_r[B_RBF] & main_r[B_RBE] & (|(mismatch & pcfg_r[3:0])),
                      ext_r[B_I1F] & ext_r[B_I1E],
                      ext_r[B_I2F] & ext_r[B_I2E]};
  assign prio_core = {edge_r[B_T0P], 1'b1, edge_r[B_RBP], ext_r[B_I1P], ext_r[B_I2P]};
  assign pend_per  = flg_view[6:0] & pen_r[6:0];
  assign prio_per  = pri_r[6:0];

  // request gating
  // priority mode is an outside input, low means single level
  always_comb begin
    if (!priority_mode_enable) begin
      // peripherals need the peripheral enable too
      high_nxt = main_r[B_GHI] & ((|pend_core) | (main_r[B_PLO] & (|pend_per)));
      low_nxt  = 1'b0;
    end else begin
      // low-priority sources need the low enable
      high_nxt = main_r[B_GHI] & ((|(pend_core & prio_core)) | (|(pend_per & prio_per)));
      low_nxt  = main_r[B_GHI] & main_r[B_PLO]
               & ((|(pend_core & ~prio_core)) | (|(pend_per & ~prio_per)));
    end
  end

  // registered request; high wins the vector when both are pending
  // vector chosen by level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= '{high: 1'b0, low: 1'b0, vector: VEC_HIGH};
    end else begin
      irq.high   <= high_nxt;
      irq.low    <= low_nxt;
      irq.vector <= (!high_nxt && low_nxt) ? VEC_LOW : VEC_HIGH;
    end
  end

  // read mux; unmapped addresses answer zero with an error
  // unimplemented bits read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    unique case (paddr)
      A_MAIN:  rdata_nxt[7:0] = main_r;
      A_EDGE:  rdata_nxt[7:0] = edge_r & M_EDGE;
      A_EXT:   rdata_nxt[7:0] = ext_r & M_EXT;
      A_FLG:   rdata_nxt[7:0] = flg_view;
      A_PEN:   rdata_nxt[7:0] = pen_r;
      A_PRI:   rdata_nxt[7:0] = pri_r;
      A_PCFG:  rdata_nxt[7:0] = pcfg_r;
      A_PORT:  rdata_nxt[3:0] = port_b_pins;
      default: err_nxt = 1'b1;
    endcase
  end

  // latched in setup so prdata and pslverr come from flops at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= err_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_global_block: assert property (
    !main_r[B_GHI] |=> !irq.high && !irq.low)
    else $error("request raised with global enable clear");

  a_prio_ignored: assert property (
    !priority_mode_enable |=> !irq.low && irq.vector == VEC_HIGH)
    else $error("low level used outside priority mode");

  a_periph_gate: assert property (
    !priority_mode_enable && !main_r[B_PLO] && !(|pend_core) |=> !irq.high)
    else $error("peripheral passed without peripheral enable");

  a_low_gate: assert property (
    priority_mode_enable && !main_r[B_PLO] |=> !irq.low)
    else $error("low request with low enable clear");

  // only a clearing write to main control in the cycle after the set may drop the flag
  a_tmr0_sticky: assert property (
    events.tmr0_ovf |=> main_r[B_T0F]
      ##1 (main_r[B_T0F] || $past(wr && paddr == A_MAIN && !pwdata[B_T0F])))
    else $error("timer-0 flag not held");

  a_set_wins: assert property (
    set_flg[B_ADF] && wr && paddr == A_FLG && !pwdata[B_ADF] |=> flg_r[B_ADF])
    else $error("event lost against clearing write");

  a_ext0_high: assert property (
    priority_mode_enable && main_r[B_GHI] && pend_core[3] |=> irq.high && irq.vector == VEC_HIGH)
    else $error("external-0 not taken as high");

  a_edge_flag: assert property (
    edge_r[B_ED1] && !$past(events.ext_lines[1]) && events.ext_lines[1] |=> ext_r[B_I1F])
    else $error("rising edge on external-1 missed");

  a_rx_mirror: assert property (
    setup && !pwrite && paddr == A_FLG |=> prdata[B_RXF] == $past(rx_r))
    else $error("receive flag read wrong");

  a_unimpl_zero: assert property (
    setup && !pwrite && paddr == A_EDGE |=> prdata[3] == 1'b0 && prdata[1] == 1'b0)
    else $error("unimplemented bit read nonzero");

  a_pullup_off: assert property (
    edge_r[B_PUD] |=> pullup_on == 4'h0)
    else $error("pull-up on while disabled");

  a_ccp_pwm: assert property (
    !flg_r[B_CCF] && events.ccp_pwm_mode && !wr |=> !flg_r[B_CCF])
    else $error("capture flag set in pulse-width mode");

  a_ext1_fall: assert property (
    !edge_r[B_ED1] && $past(events.ext_lines[1]) && !events.ext_lines[1] |=> ext_r[B_I1F])
    else $error("falling edge on external-1 missed");

  // a held mismatch must keep re-setting the flag, even against a clearing write
  a_port_flag: assert property (
    (|mismatch) |=> main_r[B_RBF])
    else $error("port-change flag not set on mismatch");

  a_flag_free: assert property (
    events.tmr1_ovf |=> flg_r[B_T1F])
    else $error("timer-1 flag not set by its event");

  a_tx_mirror: assert property (
    setup && !pwrite && paddr == A_FLG |=> prdata[B_TXF] == $past(tx_r))
    else $error("transmit flag read wrong");

  a_low_vector: assert property (
    priority_mode_enable && main_r[B_GHI] && main_r[B_PLO] && !(|(pend_core & prio_core))
    && !(|(pend_per & prio_per)) && (|(pend_core & ~prio_core))
    |=> irq.low && irq.vector == VEC_LOW)
    else $error("low request not sent to the low vector");

endmodule // iepf_top

// ===== sim/iepf_src.sv
`timescale 1ns/1ps
// stand-in for the on-chip event sources beside the interrupt logic
module iepf_src (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire iepf_pkg::iepf_evt_t fire,
  input  wire iepf_pkg::iepf_evt_t lvl,
  output iepf_pkg::iepf_evt_t      events
);
  import iepf_pkg::*;
  // pulse fields of the event struct; the rest are levels
  localparam logic [11:0] PULSE_M = 12'h8EC;
  iepf_evt_t fire_r;

  // one-cycle event pulses
  // a held request still gives one pulse, so a flag can never be set twice by one request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fire_r <= '0;
      events <= '0;
    end else begin
      fire_r <= fire;
      events <= iepf_evt_t'((fire & ~fire_r & PULSE_M) | (lvl & ~PULSE_M));
    end
  end
endmodule // iepf_src

// ===== sim/interrupt_enable_priority_flags_tb.sv
`timescale 1ns/1ps
// bench: apb master and event stimulus, with a read monitor fed by a queue of notes
module interrupt_enable_priority_flags_tb;
  import iepf_pkg::*;
  logic        pclk                 = 1'b0;
  logic        presetn              = 1'b0;
  logic        psel                 = 1'b0;
  logic        penable              = 1'b0;
  logic        pwrite               = 1'b0;
  logic [7:0]  paddr                = 8'h00;
  logic [31:0] pwdata               = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  iepf_evt_t   events;
  iepf_evt_t   fire                 = '0;
  iepf_evt_t   lvl                  = '0;
  logic [3:0]  port_b_pins          = 4'h0;
  logic [3:0]  pin_is_input         = 4'h0;
  logic        priority_mode_enable = 1'b0;
  logic [3:0]  pullup_on;
  iepf_irq_t   irq;
  logic [32:0] expq[$];
  int          fails                = 0;
  int          check_count          = 0;
  int          seed                 = 32'h62514F43;
  logic [7:0]  r;
  logic [7:0]  ra [8] = '{A_MAIN, A_EDGE, A_EXT, A_FLG, A_PEN, A_PRI, A_PCFG, A_PORT};
  logic [7:0]  rv [8] = '{R_MAIN, R_EDGE, R_EXT, R_FLG, R_PEN, R_PRI, R_PCFG, 8'h00};
  logic [7:0]  ma [4] = '{A_EDGE, A_EXT, A_FLG, A_PEN};
  logic [7:0]  mm [4] = '{M_EDGE, M_EXT, M_FLG, M_PEN};

  // 50 ns period
  always #25 pclk = ~pclk;

  iepf_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .port_b_pins(port_b_pins), .pin_is_input(pin_is_input),
    .priority_mode_enable(priority_mode_enable), .pullup_on(pullup_on), .irq(irq)
  );
  iepf_src SRC (.pclk(pclk), .presetn(presetn), .fire(fire), .lvl(lvl), .events(events));

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one apb transfer; an event request may ride on its setup cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input iepf_evt_t f);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    fire    <= f;
    @(posedge pclk);
    penable <= 1'b1;
    fire    <= '0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({1'b0, 24'h0, e});
    apb(1'b0, a, 8'h00, '0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pulse(input iepf_evt_t f);
    @(posedge pclk);
    fire <= f;
    @(posedge pclk);
    fire <= '0;
    wt(3);
  endtask

  // request lines settle one edge after the register state behind them
  task automatic ic(input logic h, input logic l);
    logic [15:0] v;
    v = (l && !h) ? VEC_LOW : VEC_HIGH;
    wt(2);
    #1;
    chk("irq", {15'h0, irq.high, irq.low, irq.vector}, {15'h0, h, l, v});
  endtask

  task automatic pchk(input logic [3:0] e);
    wt(2);
    #1;
    chk("pullup", {29'h0, pullup_on}, {29'h0, e});
  endtask

  task automatic td(input string s);
    $display("test %s done", s);
  endtask

  // read monitor: oldest note against what the slave returns
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0) chk("read_note", 33'h0, 33'h1);
      else chk("read", {pslverr, prdata}, expq.pop_front());
    end
  end

  // main sequence
  initial begin
    wt(6);
    presetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    expq.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h20, 8'h00, '0);
    td("reset");
    foreach (ma[i]) begin
      wr(ma[i], 8'hFF);
      rd(ma[i], mm[i]);
      wr(ma[i], (ma[i] == A_EDGE) ? R_EDGE : 8'h00);
    end
    r = 8'($random(seed));
    wr(A_PRI, r);
    rd(A_PRI, r & 8'h7F);
    td("masks");
    // every pulse source at once, all enables off
    pulse(iepf_evt_t'(12'h8EC));
    rd(A_MAIN, 8'h04);
    rd(A_FLG, 8'h4F);
    rd(A_FLG, 8'h4F);
    wr(A_MAIN, 8'h00);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h00);
    lvl.ccp_pwm_mode <= 1'b1;
    pulse(iepf_evt_t'(12'h020));
    rd(A_FLG, 8'h00);
    lvl.ccp_pwm_mode <= 1'b0;
    td("flags");
    // per-line edge selection with mixed polarities
    lvl.ext_lines <= 3'b111;
    wt(4);
    rd(A_MAIN, 8'h02);
    rd(A_EXT, 8'h03);
    wr(A_MAIN, 8'h00);
    wr(A_EXT, 8'h00);
    wr(A_EDGE, 8'hD5);
    lvl.ext_lines <= 3'b000;
    wt(4);
    rd(A_EXT, 8'h01);
    rd(A_MAIN, 8'h00);
    wr(A_EXT, 8'h00);
    lvl.ext_lines <= 3'b111;
    wt(4);
    rd(A_MAIN, 8'h02);
    rd(A_EXT, 8'h02);
    wr(A_MAIN, 8'h00);
    wr(A_EXT, 8'h00);
    td("edges");
    // serial buffer flags follow their sources and ignore writes
    lvl.rx_full  <= 1'b1;
    lvl.tx_empty <= 1'b1;
    wt(3);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h30);
    lvl.rx_full  <= 1'b0;
    lvl.tx_empty <= 1'b0;
    wt(3);
    rd(A_FLG, 8'h00);
    // clearing write in the very cycle of a conversion-done pulse
    apb(1'b1, A_FLG, 8'h00, iepf_evt_t'(12'h080));
    rd(A_FLG, 8'h40);
    wr(A_FLG, 8'h00);
    td("serial and collision");
    r = 8'($random(seed)) | 8'h01;
    port_b_pins <= r[3:0];
    wt(4);
    wr(A_MAIN, 8'h00);
    rd(A_MAIN, 8'h01);
    rd(A_PORT, {4'h0, r[3:0]});
    wr(A_MAIN, 8'h00);
    rd(A_MAIN, 8'h00);
    td("port change");
    wr(A_MAIN, 8'h24);
    ic(1'b0, 1'b0);
    wr(A_MAIN, 8'hA4);
    ic(1'b1, 1'b0);
    wr(A_MAIN, 8'h80);
    wr(A_PRI, 8'h00);
    wr(A_PEN, 8'h40);
    wr(A_FLG, 8'h40);
    ic(1'b0, 1'b0);
    wr(A_MAIN, 8'hC0);
    ic(1'b1, 1'b0);
    priority_mode_enable <= 1'b1;
    ic(1'b0, 1'b1);
    wr(A_MAIN, 8'h80);
    ic(1'b0, 1'b0);
    wr(A_MAIN, 8'h40);
    ic(1'b0, 1'b0);
    wr(A_PRI, 8'h40);
    wr(A_MAIN, 8'h80);
    ic(1'b1, 1'b0);
    wr(A_PEN, 8'h00);
    wr(A_MAIN, 8'h92);
    ic(1'b1, 1'b0);
    wr(A_EDGE, 8'hD1);
    wr(A_MAIN, 8'hE4);
    ic(1'b0, 1'b1);
    wr(A_MAIN, 8'hC0);
    wr(A_EXT, 8'h09);
    ic(1'b0, 1'b1);
    wr(A_EXT, 8'h49);
    ic(1'b1, 1'b0);
    wr(A_EXT, 8'h00);
    // port change needs a change-enabled pin as well
    wr(A_PCFG, 8'h00);
    port_b_pins <= ~r[3:0];
    wr(A_MAIN, 8'h88);
    ic(1'b0, 1'b0);
    wr(A_PCFG, 8'h0F);
    ic(1'b1, 1'b0);
    td("gating");
    pin_is_input <= 4'b1010;
    wr(A_PCFG, 8'hF0);
    wr(A_EDGE, 8'h55);
    pchk(4'b1010);
    wr(A_PCFG, 8'h30);
    pchk(4'b0010);
    wr(A_EDGE, 8'hD5);
    pchk(4'b0000);
    td("pullups");
    final_report();
  end
endmodule // interrupt_enable_priority_flags_tb
